// [rtl/serial_gpio_alt_function_mux.sv]
`timescale 1ns/1ps
module serial_gpio_alt_function_mux (
    // Clock and standby power-on reset
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    // Host I/O cycle
    input  wire logic [10:0] ioAddr,
    input  wire logic        ioWr,
    input  wire logic        ioRd,
    input  wire logic [7:0]  ioWdata,
    output logic      [7:0]  ioRdata,
    output logic             ioHit,
    // Configuration port control
    input  wire logic        baseStrap,
    input  wire logic        cfgEnter,
    input  wire logic        cfgExit,
    output logic             cfgActive,
    // GPIO logic, one bit per muxed pin in pin order 34..37,40..47,50..53
    input  wire logic [15:0] gpioOut,
    input  wire logic [15:0] gpioOe,
    // Serial port 3 lines
    output logic             port3_data_set_ready,
    output logic             port3_clear_to_send,
    input  wire logic        port3_request_to_send,
    input  wire logic        port3_terminal_ready,
    // Serial port 4 lines
    output logic             port4_ring_indicator,
    output logic             port4_carrier_detect,
    output logic             port4_receive_data,
    input  wire logic        port4_transmit_data,
    output logic             port4_data_set_ready,
    input  wire logic        port4_request_to_send,
    output logic             port4_clear_to_send,
    input  wire logic        port4_terminal_ready,
    // Serial port 2 and infrared lines
    output logic             port2_ring_indicator,
    output logic             port2_carrier_detect,
    output logic             port2_or_infrared_receive,
    input  wire logic        port2_or_infrared_transmit,
    // Pads
    input  wire logic [15:0] padIn,
    output logic      [15:0] padOut,
    output logic      [15:0] padOe,
    // Current selections
    output logic      [7:0]  port3_modem_pin_select,
    output logic      [7:0]  port4_data_pin_select,
    output logic      [7:0]  port4_modem_pin_select,
    output logic      [7:0]  port2_pin_select
);
    import sgam_pkg::*;

    // Returns the register slot for an index, or 4 when none matches
    function automatic logic [2:0] sgamSlot(input logic [7:0] idx);
        unique case (idx)
            SGAM_IDX_PORT3_MODEM: sgamSlot = 3'h0;
            SGAM_IDX_PORT4_DATA:  sgamSlot = 3'h1;
            SGAM_IDX_PORT4_MODEM: sgamSlot = 3'h2;
            SGAM_IDX_PORT2:       sgamSlot = 3'h3;
            default:              sgamSlot = 3'h4;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Configuration port state
    sgam_state_t state_r;
    sgam_state_t state_nxt;
    logic [10:0] base_r;
    logic [10:0] base_nxt;
    logic        strapDone_r;
    logic        strapDone_nxt;
    logic [7:0]  index_r;
    logic [7:0]  index_nxt;
    logic [7:0]  sel_r   [SGAM_REGS];
    logic [7:0]  sel_nxt [SGAM_REGS];
    logic        idxHit;
    logic        dataHit;
    logic [2:0]  slot;

    // Decode and next values
    always_comb begin
        idxHit        = (ioAddr == base_r);
        dataHit       = (ioAddr == base_r + 11'h001);
        slot          = sgamSlot(index_r);
        state_nxt     = state_r;
        base_nxt      = base_r;
        strapDone_nxt = 1'b1;
        index_nxt     = index_r;
        for (int i = 0; i < SGAM_REGS; i++) begin
            sel_nxt[i] = sel_r[i];
        end
        // Base strap caught once after reset release
        if (!strapDone_r) begin
            base_nxt = baseStrap ? SGAM_CFG_BASE_HI : SGAM_CFG_BASE_LO;
        end
        unique case (state_r)
            SGAM_RUN: begin
                if (cfgEnter) begin
                    state_nxt = SGAM_CFG;
                end
            end
            SGAM_CFG: begin
                if (cfgExit) begin
                    state_nxt = SGAM_RUN;
                end
                if (ioWr && idxHit) begin
                    index_nxt = ioWdata;
                end
                if (ioWr && dataHit && slot < 3'h4) begin
                    sel_nxt[slot[1:0]] = ioWdata;
                end
            end
            default: state_nxt = SGAM_RUN;
        endcase
    end

    // Registers, cleared on standby power-on reset
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_r     <= SGAM_RUN;
            base_r      <= SGAM_CFG_BASE_LO;
            strapDone_r <= 1'b0;
            index_r     <= 8'h00;
            for (int i = 0; i < SGAM_REGS; i++) begin
                sel_r[i] <= SGAM_SEL_RESET;
            end
        end else begin
            state_r     <= state_nxt;
            base_r      <= base_nxt;
            strapDone_r <= strapDone_nxt;
            index_r     <= index_nxt;
            for (int i = 0; i < SGAM_REGS; i++) begin
                sel_r[i] <= sel_nxt[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path: registered data
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    // Index reads back; data reads the selected register or zero
    always_comb begin
        rdata_nxt = 8'h00;
        if (state_r == SGAM_CFG && ioRd) begin
            if (idxHit) begin
                rdata_nxt = index_r;
            end else if (dataHit && slot < 3'h4) begin
                rdata_nxt = sel_r[slot[1:0]];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Outputs
    assign ioRdata   = rdata_r;
    assign ioHit     = (state_r == SGAM_CFG) && (idxHit || dataHit);
    assign cfgActive = (state_r == SGAM_CFG);
    assign port3_modem_pin_select = sel_r[0];
    assign port4_data_pin_select  = sel_r[1];
    assign port4_modem_pin_select = sel_r[2];
    assign port2_pin_select       = sel_r[3];

    ////////////////////////////////////////////////////////////////////////
    // Pin routing; pin p uses register p/4, field p%4
    logic [15:0] altIsOut;
    logic [15:0] altOut;
    logic [15:0] altIn;

    // Direction of each alternate function and outgoing port lines
    // Pins 35,37,43,45,47,53 carry port outputs
    assign altIsOut = 16'h8a8a;
    assign altOut   = {port2_or_infrared_transmit, 1'b0, 2'h0,
                       port4_terminal_ready, 1'b0, port4_request_to_send,
                       1'b0, port4_transmit_data, 3'h0,
                       port3_terminal_ready, 1'b0, port3_request_to_send,
                       1'b0};

    // Incoming lines idle high when not selected
    assign port3_data_set_ready      = altIn[0];
    assign port3_clear_to_send       = altIn[2];
    assign port4_ring_indicator      = altIn[4];
    assign port4_carrier_detect      = altIn[5];
    assign port4_receive_data        = altIn[6];
    assign port4_data_set_ready      = altIn[8];
    assign port4_clear_to_send       = altIn[10];
    assign port2_ring_indicator      = altIn[12];
    assign port2_carrier_detect      = altIn[13];
    assign port2_or_infrared_receive = altIn[14];

    // One cell per pin
    for (genvar p = 0; p < SGAM_PINS; p++) begin : gPin
        sgam_pin_cell uCell (
            .fieldCode   (sel_r[p / SGAM_FIELDS][(p % SGAM_FIELDS) * 2 +: 2]),
            .altIsOutput (altIsOut[p]),
            .gpioOut     (gpioOut[p]),
            .gpioOe      (gpioOe[p]),
            .altOut      (altOut[p]),
            .altIn       (altIn[p]),
            .padIn       (padIn[p]),
            .padOut      (padOut[p]),
            .padOe       (padOe[p])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    reg_gate_a: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        (state_r == SGAM_RUN) |=> $stable(sel_r[0]) && $stable(sel_r[3]))
        else $error("select changed outside config state");
    reserved_safe_a: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        (sel_r[1][7]) |-> !padOe[7])
        else $error("reserved code drives pin");
    route_p3dtr_a: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        (sel_r[0][7:6] == 2'h1) |-> padOe[3]
        && padOut[3] == port3_terminal_ready)
        else $error("pin 37 not routed to port 3 DTR");
    route_p3rts_a: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        (sel_r[0][3:2] == 2'h1) |-> padOut[1] == port3_request_to_send)
        else $error("pin 35 not routed to port 3 RTS");
    route_p4rxd_a: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        (sel_r[1][5:4] == 2'h1) |-> port4_receive_data == padIn[6]
        && !padOe[6])
        else $error("pin 42 not routed to port 4 RXD");
    route_p4rts_a: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        (sel_r[2][3:2] == 2'h1) |-> padOut[9] == port4_request_to_send)
        else $error("pin 45 not routed to port 4 RTS");
    route_p2tx_a: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        (sel_r[3][7:6] == 2'h1) |-> padOut[15]
        == port2_or_infrared_transmit)
        else $error("pin 53 not routed to port 2 transmit");
    route_p3dsr_a: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        (sel_r[0][1:0] == 2'h1) |-> port3_data_set_ready == padIn[0])
        else $error("pin 34 not routed to port 3 DSR");
    write_take_a: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        (state_r == SGAM_CFG && ioWr && dataHit && slot == 3'h2
        && !cfgExit) |=> sel_r[2] == $past(ioWdata))
        else $error("select write not stored");
    gpio_default_a: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        (sel_r[3][1:0] == 2'h0) |-> padOe[12] == gpioOe[12])
        else $error("code 00 does not give GPIO");
endmodule

// [rtl/sgam_pin_cell.sv]
`timescale 1ns/1ps
// One pin: the GPIO logic, one serial-port line or, for reserved codes, nothing owns the pad
module sgam_pin_cell (
    // Selection
    input  wire logic [1:0] fieldCode,
    input  wire logic       altIsOutput,
    // GPIO side
    input  wire logic       gpioOut,
    input  wire logic       gpioOe,
    // Serial-port side
    input  wire logic       altOut,
    output logic            altIn,
    // Pad side
    input  wire logic       padIn,
    output logic            padOut,
    output logic            padOe
);
    import sgam_pkg::*;
    logic altSel;
    logic gpioSel;

    // Only code 01 connects the function; reserved codes leave pad undriven
    always_comb begin
        altSel  = (fieldCode == SGAM_CODE_ALT);
        gpioSel = (fieldCode == SGAM_CODE_GPIO);
        altIn   = altSel && !altIsOutput ? padIn : 1'b1;
        padOut  = altSel ? altOut : (gpioSel ? gpioOut : 1'b0);
        padOe   = altSel ? altIsOutput : (gpioSel ? gpioOe : 1'b0);
    end
endmodule

// [rtl/sgam_pkg.sv]
package sgam_pkg;
    // Indexed configuration port, base fixed by the strap at reset
    localparam logic [10:0] SGAM_CFG_BASE_LO    = 11'h02e;
    localparam logic [10:0] SGAM_CFG_BASE_HI    = 11'h04e;
    // Register indices of the pin select registers
    localparam logic [7:0]  SGAM_IDX_PORT3_MODEM = 8'h49;
    localparam logic [7:0]  SGAM_IDX_PORT4_DATA  = 8'h4a;
    localparam logic [7:0]  SGAM_IDX_PORT4_MODEM = 8'h4b;
    localparam logic [7:0]  SGAM_IDX_PORT2       = 8'h4c;
    // Reset value of every select register
    localparam logic [7:0]  SGAM_SEL_RESET       = 8'h00;
    // Field position and width: field n sits at bits 2n+1:2n
    localparam int          SGAM_FIELD_W         = 2;
    localparam int          SGAM_FIELDS          = 4;
    localparam int          SGAM_REGS            = 4;
    localparam int          SGAM_PINS            = 16;
    // Select codes
    localparam logic [1:0]  SGAM_CODE_GPIO       = 2'h0;
    localparam logic [1:0]  SGAM_CODE_ALT        = 2'h1;
    // Access state of the configuration port
    typedef enum logic [1:0] {
        SGAM_RUN = 2'b01,
        SGAM_CFG = 2'b10
    } sgam_state_t;
endpackage

// [verif/sgam_far_side.sv]
`timescale 1ns/1ps
// Pads, GPIO logic and serial-port transmit lines around the mux
module sgam_far_side (
    // Stimulus phase from the bench
    input  wire logic        phase,
    // Pad and GPIO side
    output logic      [15:0] padIn,
    output logic      [15:0] gpioOut,
    output logic      [15:0] gpioOe,
    // Serial-port output levels, one per outgoing port line
    output logic      [5:0]  txLvl
);
    // Outside devices drive a phase-dependent pattern on the pads
    assign padIn   = phase ? 16'ha5c3 : 16'h5a3c;
    assign gpioOut = ~padIn;
    // Direction matches each pin's alternate role, or all inputs
    assign gpioOe  = phase ? 16'h8a8a : 16'h0000;
    // Every line flips between phases, lines differ within a phase
    assign txLvl   = phase ? 6'h2d : 6'h12;
endmodule

// [verif/tb.sv]
`timescale 1ns/1ps
module tb;
    import sgam_pkg::*;
    localparam logic [15:0] OM = 16'h8a8a;
    logic        clk_sys, resetn, ioWr, ioRd, baseStrap, cfgEnter, cfgExit;
    logic        phase, ioHit, cfgActive;
    logic [5:0]  txLvl;
    logic [10:0] ioAddr;
    logic [7:0]  ioWdata, ioRdata, rd, s0, s1, s2, s3;
    logic [15:0] padIn, padOut, padOe, gpioOut, gpioOe, portIn, portOut;
    logic        p3Dsr, p3Cts, p4Ri, p4Dcd, p4Rxd, p4Dsr, p4Cts;
    logic        p2Ri, p2Dcd, p2Rx;
    logic [7:0]  sel [4];
    logic [7:0]  idx [4];
    logic [7:0]  pats [6];
    int          n_fail, tests_run;

    ////////////////////////////////////////////////////////////////////
    // Port inputs gathered in pin order, output pins read as 1
    assign portIn = {1'b1, p2Rx, p2Dcd, p2Ri, 1'b1, p4Cts, 1'b1, p4Dsr,
                     1'b1, p4Rxd, p4Dcd, p4Ri, 1'b1, p3Cts, 1'b1, p3Dsr};
    // Port output lines placed at the pin that should carry each
    assign portOut = {txLvl[5], 3'h0, txLvl[4], 1'b0, txLvl[3], 1'b0,
                      txLvl[2], 3'h0, txLvl[1], 1'b0, txLvl[0], 1'b0};

    sgam_far_side u_far (.phase(phase), .padIn(padIn), .gpioOut(gpioOut),
        .gpioOe(gpioOe), .txLvl(txLvl));

    serial_gpio_alt_function_mux u_dut (
        .clk_sys(clk_sys), .resetn(resetn), .ioAddr(ioAddr), .ioWr(ioWr),
        .ioRd(ioRd), .ioWdata(ioWdata), .ioRdata(ioRdata), .ioHit(ioHit),
        .baseStrap(baseStrap), .cfgEnter(cfgEnter), .cfgExit(cfgExit),
        .cfgActive(cfgActive), .gpioOut(gpioOut), .gpioOe(gpioOe),
        .port3_data_set_ready(p3Dsr), .port3_clear_to_send(p3Cts),
        .port3_request_to_send(txLvl[0]), .port3_terminal_ready(txLvl[1]),
        .port4_ring_indicator(p4Ri), .port4_carrier_detect(p4Dcd),
        .port4_receive_data(p4Rxd), .port4_transmit_data(txLvl[2]),
        .port4_data_set_ready(p4Dsr), .port4_request_to_send(txLvl[3]),
        .port4_clear_to_send(p4Cts), .port4_terminal_ready(txLvl[4]),
        .port2_ring_indicator(p2Ri), .port2_carrier_detect(p2Dcd),
        .port2_or_infrared_receive(p2Rx),
        .port2_or_infrared_transmit(txLvl[5]), .padIn(padIn),
        .padOut(padOut), .padOe(padOe), .port3_modem_pin_select(s0),
        .port4_data_pin_select(s1), .port4_modem_pin_select(s2),
        .port2_pin_select(s3));

    ////////////////////////////////////////////////////////////////////
    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // Compare and count
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One host I/O cycle, read data taken at the negedge that ends the strobe
    task automatic io(input logic [10:0] a, input logic [7:0] d,
                      input logic wr);
        @(negedge clk_sys);
        ioAddr  = a;
        ioWdata = d;
        ioWr    = wr;
        ioRd    = !wr;
        @(negedge clk_sys);
        ioWr = 1'b0;
        ioRd = 1'b0;
        rd   = ioRdata;
    endtask

    task automatic wreg(input logic [10:0] b, input logic [7:0] i,
                        input logic [7:0] d);
        io(b, i, 1'b1);
        io(b + 11'h001, d, 1'b1);
    endtask

    task automatic rreg(input logic [10:0] b, input logic [7:0] i);
        io(b, i, 1'b1);
        io(b + 11'h001, 8'h00, 1'b0);
    endtask

    // Pulse a state-control input for one cycle
    task automatic cfg(input logic enter);
        @(negedge clk_sys);
        cfgEnter = enter;
        cfgExit  = !enter;
        @(negedge clk_sys);
        cfgEnter = 1'b0;
        cfgExit  = 1'b0;
    endtask

    task automatic do_reset;
        @(negedge clk_sys);
        resetn = 1'b0;
        repeat (2) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (2) @(negedge clk_sys);
    endtask

    // Expected pad and port levels from the select fields
    task automatic pins;
        logic [15:0] eOe, eOut, eIn, m;
        logic [1:0]  c;
        for (int i = 0; i < 16; i++) begin
            c       = sel[i/4][2*(i%4)+:2];
            eOe[i]  = (c == 2'h0) ? gpioOe[i] : (c == 2'h1 && OM[i]);
            eOut[i] = (c == 2'h0) ? gpioOut[i]
                    : ((c == 2'h1 && OM[i]) ? portOut[i] : 1'b0);
            eIn[i]  = (c == 2'h1 && !OM[i]) ? padIn[i] : 1'b1;
            m[i]    = !(c == 2'h1 && !OM[i]);
        end
        chk(padOe, eOe);
        chk(padOut & m, eOut & m);
        chk(portIn | OM, eIn | OM);
    endtask

    task automatic both_phases;
        for (int p = 0; p < 2; p++) begin
            @(negedge clk_sys);
            phase = p[0];
            #1;
            pins();
        end
    endtask

    task automatic report_and_stop;
        if (n_fail == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    // Watchdog
    initial begin
        #400000;
        n_fail++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        idx  = '{SGAM_IDX_PORT3_MODEM, SGAM_IDX_PORT4_DATA,
                 SGAM_IDX_PORT4_MODEM, SGAM_IDX_PORT2};
        pats = '{8'h00, 8'h55, 8'haa, 8'hff, 8'h1b, 8'he4};
        sel  = '{8'h00, 8'h00, 8'h00, 8'h00};
        n_fail = 0;
        tests_run = 0;
        {ioWr, ioRd, baseStrap, cfgEnter, cfgExit, phase} = 6'h00;
        ioAddr  = 11'h000;
        ioWdata = 8'h00;
        resetn  = 1'b0;
        repeat (2) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk({s0, s1}, 16'h0000);
        chk({s2, s3}, 16'h0000);
        both_phases();
        // Outside the configuration state nothing is taken
        wreg(SGAM_CFG_BASE_LO, idx[0], 8'hff);
        chk({s0, 7'h00, ioHit}, 16'h0000);
        cfg(1'b1);
        chk({15'h0000, cfgActive}, 16'h0001);
        for (int k = 0; k < 6; k++) begin
            for (int r = 0; r < 4; r++) begin
                sel[r] = pats[k] ^ {6'h00, r[1:0]};
                wreg(SGAM_CFG_BASE_LO, idx[r], sel[r]);
            end
            for (int r = 0; r < 4; r++) begin
                rreg(SGAM_CFG_BASE_LO, idx[r]);
                chk({8'h00, rd}, {8'h00, sel[r]});
            end
            chk({s0, s1}, {sel[0], sel[1]});
            chk({s2, s3}, {sel[2], sel[3]});
            chk({15'h0000, ioHit}, 16'h0001);
            both_phases();
        end
        // Indices outside the block are refused
        wreg(SGAM_CFG_BASE_LO, 8'h48, 8'hff);
        rreg(SGAM_CFG_BASE_LO, 8'h4d);
        chk({8'h00, rd}, 16'h0000);
        io(SGAM_CFG_BASE_LO, 8'h00, 1'b0);
        chk({8'h00, rd}, 16'h004d);
        chk({s0, s3}, {sel[0], sel[3]});
        // After leaving, writes are ignored and reads give 0
        cfg(1'b0);
        wreg(SGAM_CFG_BASE_LO, idx[0], 8'h55);
        rreg(SGAM_CFG_BASE_LO, idx[1]);
        chk({s0, rd}, {sel[0], 8'h00});
        // Mid-run reset with the other strap
        baseStrap = 1'b1;
        do_reset();
        chk({s0, s1, 7'h00, cfgActive}, 16'h0000);
        chk({s2, s3}, 16'h0000);
        cfg(1'b1);
        wreg(SGAM_CFG_BASE_LO, idx[0], 8'h55);
        chk({8'h00, s0}, 16'h0000);
        chk({15'h0000, ioHit}, 16'h0000);
        wreg(SGAM_CFG_BASE_HI, idx[3], 8'h56);
        rreg(SGAM_CFG_BASE_HI, idx[3]);
        chk({s3, rd}, 16'h5656);
        report_and_stop();
    end
endmodule
